// [logic/erpc_ram.sv]
// True dual-port RAM with address hold, byte enables, clear and read enable
//
// Register access over AHB-Lite and the placing of the registers were decided locally.
`timescale 1ns/100ps
module erpc_ram #(
    parameter int ADDR_W = erpc_pkg::ERPC_ADDR_W,
    parameter int DATA_W = erpc_pkg::ERPC_DATA_W,
    parameter int BYTE_W = erpc_pkg::ERPC_BYTE_W,
    parameter bit IS_LARAM = 1'b0,
    parameter int BE_W = DATA_W / BYTE_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Port A
    input wire logic [ADDR_W-1:0] addr_a,
    input wire logic addr_stall_a,
    input wire logic we_a,
    input wire logic [BE_W-1:0] byteena_a,
    input wire logic rden_a,
    input wire logic [DATA_W-1:0] data_a,
    output logic [DATA_W-1:0] q_a,
    // Port B
    input wire logic [ADDR_W-1:0] addr_b,
    input wire logic addr_stall_b,
    input wire logic we_b,
    input wire logic [BE_W-1:0] byteena_b,
    input wire logic rden_b,
    input wire logic [DATA_W-1:0] data_b,
    output logic [DATA_W-1:0] q_b,
    // Output clear
    input wire logic out_clear
);
    import erpc_pkg::*;

    localparam int DEPTH = 1 << ADDR_W;
    // Legal byte size and whole-multiple width, else enables are ignored
    localparam bit SIZE_OK = (BYTE_W == 8) || (BYTE_W == 9) ||
        (IS_LARAM && ((BYTE_W == 5) || (BYTE_W == 10)));
    // Both ports share DATA_W, so the width ratio is always 1
    localparam bit RATIO_OK = 1'b1;
    localparam bit BE_OK = RATIO_OK && SIZE_OK &&
        (DATA_W % BYTE_W == 0);
    // Logic-array blocks have no output clear
    localparam bit CLR_OK = !IS_LARAM;

    // Storage, never reset so a clear cannot touch contents
    logic [DATA_W-1:0] mem [DEPTH];

    // Control and bus state
    logic [ERPC_CTRL_W-1:0] ctrl_r;
    logic [31:0] hrdata_r;
    logic dp_wr_r;
    logic [7:0] dp_addr_r;

    // Per-port views as arrays
    logic [ADDR_W-1:0] p_addr [2];
    logic p_stall [2];
    logic p_we [2];
    logic [BE_W-1:0] p_be [2];
    logic p_rden [2];
    logic [DATA_W-1:0] p_data [2];
    logic [ADDR_W-1:0] ad [2];
    logic [ADDR_W-1:0] held [2];
    logic [DATA_W-1:0] m [2];
    logic [DATA_W-1:0] stored [2];
    logic [DATA_W-1:0] rd_val [2];
    logic rden_eff [2];
    logic [DATA_W-1:0] q_r [2];
    logic clr_held_r [2];

    // Port fan-in
    assign p_addr[0] = addr_a;
    assign p_addr[1] = addr_b;
    assign p_stall[0] = addr_stall_a;
    assign p_stall[1] = addr_stall_b;
    assign p_we[0] = we_a;
    assign p_we[1] = we_b;
    assign p_be[0] = byteena_a;
    assign p_be[1] = byteena_b;
    assign p_rden[0] = rden_a;
    assign p_rden[1] = rden_b;
    assign p_data[0] = data_a;
    assign p_data[1] = data_b;
    assign q_a = q_r[0];
    assign q_b = q_r[1];

    // Control decode
    wire rdw_new = ctrl_r[ERPC_CTRL_RDW_NEW];
    wire rdw_dc = ctrl_r[ERPC_CTRL_RDW_DC];
    wire mask_stored = ctrl_r[ERPC_CTRL_MASK_STORED];
    wire hold_to_read = ctrl_r[ERPC_CTRL_HOLD_TO_READ];
    wire clr_act = CLR_OK && out_clear;

    genvar p, i;
    generate
        for (p = 0; p < 2; p++) begin : g_port
            // Independent address hold per port
            // Clear is not wired in, so held addresses survive it
            erpc_addr_hold #(
                .AW(ADDR_W)
            ) u_hold (
                .mclk(mclk),
                .rstn(rstn),
                .addr(p_addr[p]),
                .addr_stall(p_stall[p]),
                .addr_eff(ad[p]),
                .addr_r(held[p])
            );

            // Bit mask: bit i follows enable bit i/BYTE_W, LSB first
            for (i = 0; i < DATA_W; i++) begin : g_bit
                if (BE_OK) begin : g_be
                    assign m[p][i] = p_be[p][i / BYTE_W];
                end else begin : g_nobe
                    assign m[p][i] = 1'b1;
                end
            end

            assign stored[p] = mem[ad[p]];
            // Logic-array blocks always read
            assign rden_eff[p] = IS_LARAM || p_rden[p];
            // Same-port read_during_write: new, old or don't care (zeros)
            // Masked bytes show stored data or zeros in new-data mode
            assign rd_val[p] = !p_we[p] ? stored[p] :
                rdw_dc ? '0 :
                rdw_new ? ((p_data[p] & m[p]) |
                    (mask_stored ? (stored[p] & ~m[p]) : '0)) :
                stored[p];

            // Output stage; clear wins, then hold or load
            always_ff @(posedge mclk) begin
                if (!rstn) begin
                    q_r[p] <= '0;
                    clr_held_r[p] <= 1'b0;
                end else if (clr_act) begin
                    q_r[p] <= '0;
                    clr_held_r[p] <= 1'b1;
                end else if (rden_eff[p] ||
                        (clr_held_r[p] && !hold_to_read)) begin
                    q_r[p] <= rd_val[p];
                    clr_held_r[p] <= 1'b0;
                end
            end
        end
    endgenerate

    // Array writes; enabled bytes only, port B wins a same-address clash
    always_ff @(posedge mclk) begin
        if (we_a) begin
            mem[ad[0]] <= (mem[ad[0]] & ~m[0]) | (data_a & m[0]);
        end
        if (we_b) begin
            mem[ad[1]] <= (mem[ad[1]] & ~m[1]) | (data_b & m[1]);
        end
    end

    // Bus address-phase decode
    wire ahb_take = hsel && hready && htrans[1];
    wire sel_ctrl = haddr[7:0] == ERPC_CTRL_OFS && haddr[31:8] == 24'h0;
    wire sel_stat = haddr[7:0] == ERPC_STATUS_OFS && haddr[31:8] == 24'h0;
    wire [31:0] stat_word = {29'h0, BE_OK, clr_held_r[1], clr_held_r[0]};
    wire [31:0] rd_word = sel_ctrl ? {28'h0, ctrl_r} :
        sel_stat ? stat_word : 32'h0;
    wire ctrl_wr = dp_wr_r && dp_addr_r == ERPC_CTRL_OFS;

    // Bus slave: zero wait states, read data set up in address phase
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            dp_wr_r <= 1'b0;
            dp_addr_r <= 8'h00;
            hrdata_r <= 32'h0;
        end else begin
            // Upper address bits checked here so aliases cannot write
            dp_wr_r <= ahb_take && hwrite && sel_ctrl;
            dp_addr_r <= haddr[7:0];
            if (ahb_take && !hwrite) begin
                hrdata_r <= rd_word;
            end
        end
    end

    // Control register, written in the data phase
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ctrl_r <= ERPC_CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_r <= hwdata[ERPC_CTRL_W-1:0];
        end
    end

    // Constant handshake outputs still come from flip-flops
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            hreadyout <= 1'b0;
            hresp <= ERPC_HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= ERPC_HRESP_OKAY;
        end
    end
    assign hrdata = hrdata_r;

    // Checks on the design's own behaviour
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    a_stall_holds_addr: assert property (
        addr_stall_a ##1 addr_stall_a |-> ad[0] == $past(ad[0]))
        else $error("stalled address changed");
    a_stall_port_indep: assert property (
        addr_stall_a && !addr_stall_b |-> ad[1] == addr_b)
        else $error("stall on A disturbed port B");
    a_free_capture: assert property (
        !addr_stall_b |=> held[1] == $past(addr_b))
        else $error("address not captured while hold low");
    a_masked_keep: assert property (
        we_a && !(we_b && ad[1] == ad[0]) |=>
        (mem[$past(ad[0])] & ~$past(m[0])) ==
        ($past(stored[0]) & ~$past(m[0])))
        else $error("masked byte was overwritten");
    a_lsb_byte: assert property (
        BE_OK |-> m[0][0] == byteena_a[0] &&
        m[0][BYTE_W-1] == byteena_a[0])
        else $error("enable bit 0 not on lowest byte");
    a_be_fallback: assert property (
        !BE_OK |-> &m[0])
        else $error("enables used on illegal geometry");
    a_clear_output: assert property (
        clr_act |=> q_a == '0 && q_b == '0 [*1])
        else $error("clear did not empty outputs");
    a_clear_to_clock: assert property (
        clr_held_r[0] && !hold_to_read && !clr_act |=>
        q_a == $past(rd_val[0]))
        else $error("cleared output did not reload on clock");
    a_clear_to_read: assert property (
        clr_held_r[0] && hold_to_read && !rden_eff[0] && !clr_act
        ##1 !rden_eff[0] && !clr_act |=> q_a == '0)
        else $error("cleared output left early");
    a_rden_hold: assert property (
        !rden_eff[1] && !clr_held_r[1] && !clr_act |=> $stable(q_b))
        else $error("output moved with read enable low");
    a_new_data: assert property (
        we_a && rden_a && rdw_new && !rdw_dc && !clr_act |=>
        (q_a & $past(m[0])) == ($past(data_a) & $past(m[0])))
        else $error("new data not shown on write edge");
    a_old_data: assert property (
        we_b && rden_b && !rdw_new && !rdw_dc && !clr_act |=>
        q_b == $past(stored[1]))
        else $error("old data not shown on write edge");

    c_stall_read: cover property (
        addr_stall_a && rden_a ##1 addr_stall_a && rden_a);
    c_clear_then_read: cover property (
        clr_act ##1 !clr_act ##[1:4] rden_a);
    c_partial_write: cover property (
        we_a && rden_a && !(&m[0]) && |m[0]);
endmodule : erpc_ram

// [logic/erpc_pkg.sv]
// Shared constants for the embedded RAM port control block
package erpc_pkg;
    // Register byte offsets on the AHB-Lite bus
    localparam logic [7:0] ERPC_CTRL_OFS = 8'h00;
    localparam logic [7:0] ERPC_STATUS_OFS = 8'h04;
    // Control register field positions
    localparam int ERPC_CTRL_RDW_NEW = 0;
    localparam int ERPC_CTRL_RDW_DC = 1;
    localparam int ERPC_CTRL_MASK_STORED = 2;
    localparam int ERPC_CTRL_HOLD_TO_READ = 3;
    localparam int ERPC_CTRL_W = 4;
    // Control reset: new-data read_during_write, clear holds to clock
    localparam logic [3:0] ERPC_CTRL_RST = 4'h1;
    // Status register field positions
    localparam int ERPC_STAT_HELD_A = 0;
    localparam int ERPC_STAT_HELD_B = 1;
    localparam int ERPC_STAT_BE_OK = 2;
    // Default geometry
    localparam int ERPC_ADDR_W = 6;
    localparam int ERPC_DATA_W = 18;
    localparam int ERPC_BYTE_W = 9;
    // AHB transfer type and response codes
    localparam logic [1:0] ERPC_HTRANS_NONSEQ = 2'h2;
    localparam logic ERPC_HRESP_OKAY = 1'h0;
endpackage : erpc_pkg

// [logic/erpc_addr_hold.sv]
// Per-port address capture register with address hold
`timescale 1ns/100ps
module erpc_addr_hold #(
    parameter int AW = 6
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // User side
    input wire logic [AW-1:0] addr,
    input wire logic addr_stall,
    // Address seen by the array this cycle and the held copy
    output logic [AW-1:0] addr_eff,
    output logic [AW-1:0] addr_r
);
    import erpc_pkg::*;

    // While stalled the array keeps using the earlier capture
    assign addr_eff = addr_stall ? addr_r : addr;

    // Capture every cycle unless stalled; stall low is normal capture
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            addr_r <= '0;
        end else if (!addr_stall) begin
            addr_r <= addr;
        end
    end
endmodule : erpc_addr_hold

// [dv/erpc_user_port.sv]
// Behavioural user logic that drives one memory port of the RAM
`timescale 1ns/100ps
module erpc_user_port #(
    parameter int AW = 6,
    parameter int DW = 18,
    parameter int BW = 2
) (
    // Memory port pins
    output logic [AW-1:0] addr,
    output logic stall,
    output logic we,
    output logic [BW-1:0] be,
    output logic rden,
    output logic [DW-1:0] data
);
    // Quiet port at time zero, address hold left inactive
    initial begin
        addr = '0;
        stall = 1'b0;
        we = 1'b0;
        be = '0;
        rden = 1'b0;
        data = '0;
    end

    // Called just after a rising edge; all pins move together
    task automatic put(input logic [AW-1:0] a, input logic s, input logic w,
        input logic [BW-1:0] b, input logic r, input logic [DW-1:0] d);
        addr <= a;
        stall <= s;
        we <= w;
        be <= b;
        rden <= r;
        // Unused write data flips so a stale value cannot match by luck
        data <= w ? d : ~data;
    endtask : put
endmodule : erpc_user_port

// [dv/embedded_ram_port_controls_bench.sv]
// Self-checking bench for the dual-port RAM port controls
`timescale 1ns/100ps
module embedded_ram_port_controls_bench;
    import erpc_pkg::*;
    typedef struct packed {
        logic [3:0] c;
        logic [5:0] a;
        logic s, w;
        logic [1:0] b;
        logic r;
        logic [17:0] d, q;
    } erpc_row_type;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic out_clear = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic hresp;
    wire logic hready;
    logic [5:0] addr_a, addr_b;
    logic addr_stall_a, addr_stall_b, we_a, we_b, rden_a, rden_b;
    logic [1:0] byteena_a, byteena_b;
    logic [17:0] data_a, data_b, q_a, q_b;
    logic [3:0] ctrl = 4'h1;
    int fail_count = 0;
    int n_compared = 0;
    // Ctrl, addr, hold, we, byteena, rden, data, expected q on port A
    erpc_row_type rows [0:11] = '{
        '{4'h1, 6'h05, 1'b0, 1'b1, 2'h3, 1'b1, 18'h3ffff, 18'h3ffff},
        '{4'h1, 6'h05, 1'b0, 1'b1, 2'h1, 1'b1, 18'h00000, 18'h00000},
        '{4'h1, 6'h05, 1'b0, 1'b0, 2'h0, 1'b1, 18'h00000, 18'h3fe00},
        '{4'h1, 6'h05, 1'b0, 1'b1, 2'h2, 1'b0, 18'h15555, 18'h3fe00},
        '{4'h1, 6'h05, 1'b0, 1'b0, 2'h0, 1'b1, 18'h00000, 18'h15400},
        '{4'h1, 6'h09, 1'b1, 1'b0, 2'h0, 1'b1, 18'h00000, 18'h15400},
        '{4'h1, 6'h09, 1'b0, 1'b1, 2'h3, 1'b1, 18'h12345, 18'h12345},
        '{4'h0, 6'h09, 1'b0, 1'b1, 2'h3, 1'b1, 18'h00000, 18'h12345},
        '{4'h0, 6'h09, 1'b0, 1'b0, 2'h0, 1'b1, 18'h00000, 18'h00000},
        '{4'h5, 6'h05, 1'b0, 1'b1, 2'h1, 1'b1, 18'h3ffff, 18'h155ff},
        '{4'h2, 6'h05, 1'b0, 1'b1, 2'h3, 1'b1, 18'h3ffff, 18'h00000},
        '{4'h2, 6'h05, 1'b0, 1'b0, 2'h0, 1'b1, 18'h00000, 18'h3ffff}
    };

    erpc_user_port PA (.addr(addr_a), .stall(addr_stall_a), .we(we_a),
        .be(byteena_a), .rden(rden_a), .data(data_a));
    erpc_user_port PB (.addr(addr_b), .stall(addr_stall_b), .we(we_b),
        .be(byteena_b), .rden(rden_b), .data(data_b));
    erpc_ram DUT (.mclk, .rstn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready, .hreadyout(hready), .hrdata, .hresp,
        .addr_a, .addr_stall_a, .we_a, .byteena_a, .rden_a, .data_a, .q_a,
        .addr_b, .addr_stall_b, .we_b, .byteena_b, .rden_b, .data_b, .q_b,
        .out_clear);

    // 10 MHz clock
    initial forever #50 mclk = ~mclk;

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Bounded wait for hready sampled high at a rising edge
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            chk("hready", 32'h1, {31'h0, hready});
            final_report();
        end
    endtask : wait_ready

    // One single AHB-Lite word transfer, entered just after an edge
    task automatic ahb(input logic w, input logic [31:0] a,
        input logic [31:0] wd, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= ERPC_HTRANS_NONSEQ;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        r = hrdata;
        chk("hresp", {31'h0, ERPC_HRESP_OKAY}, {31'h0, hresp});
    endtask : ahb

    // Port A access, then an idle edge; q_a checked mid-cycle
    task automatic step(input logic [5:0] a, input logic s, input logic w,
        input logic [1:0] b, input logic r, input logic [17:0] d,
        input logic [17:0] q);
        PA.put(a, s, w, b, r, d);
        @(posedge mclk);
        PA.put(a, 1'b0, 1'b0, 2'h0, 1'b0, d);
        @(negedge mclk);
        chk("q_a", {14'h0, q}, {14'h0, q_a});
    endtask : step

    initial begin
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        chk("hready", 32'h0, {31'h0, hready});
        chk("q_a", 32'h0, {14'h0, q_a});
        @(posedge mclk);
        rstn <= 1'b1;
        // First request only once hreadyout is up
        @(posedge mclk);
        ahb(1'b0, {24'h0, ERPC_CTRL_OFS}, 32'h0, rd);
        chk("ctrl", 32'h1, rd);
        ahb(1'b1, 32'h10, 32'hffffffff, rd);
        ahb(1'b0, 32'h10, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        // Table rows; ctrl rewritten only when a row changes mode
        for (int i = 0; i < 12; i++) begin
            if (rows[i].c !== ctrl) begin
                ctrl = rows[i].c;
                ahb(1'b1, {24'h0, ERPC_CTRL_OFS}, {28'h0, ctrl}, rd);
            end
            step(rows[i].a, rows[i].s, rows[i].w, rows[i].b, rows[i].r,
                rows[i].d, rows[i].q);
            @(posedge mclk);
        end
        // Port B holds address 5 while port A moves freely
        PB.put(6'h05, 1'b0, 1'b0, 2'h0, 1'b1, 18'h0);
        @(posedge mclk);
        PB.put(6'h00, 1'b1, 1'b0, 2'h0, 1'b1, 18'h0);
        step(6'h09, 1'b0, 1'b0, 2'h0, 1'b1, 18'h0, 18'h0);
        chk("q_b", 32'h3ffff, {14'h0, q_b});
        @(posedge mclk);
        PB.put(6'h05, 1'b0, 1'b0, 2'h0, 1'b0, 18'h0);
        // Clear released at the next clock, then at the next read
        for (int m = 0; m < 2; m++) begin
            ahb(1'b1, {24'h0, ERPC_CTRL_OFS}, m ? 32'h9 : 32'h1, rd);
            step(6'h05, 1'b0, 1'b0, 2'h0, 1'b1, 18'h0, 18'h3ffff);
            @(posedge mclk);
            // Clear only while no write is under way
            out_clear <= 1'b1;
            step(6'h05, 1'b0, 1'b0, 2'h0, 1'b0, 18'h0, 18'h0);
            @(posedge mclk);
            out_clear <= 1'b0;
            // Idle edge: reload at the clock, or stay cleared until a read
            step(6'h05, 1'b0, 1'b0, 2'h0, 1'b0, 18'h0,
                m ? 18'h0 : 18'h3ffff);
            @(posedge mclk);
            ahb(1'b0, {24'h0, ERPC_STATUS_OFS}, 32'h0, rd);
            chk("status", m ? 32'h7 : 32'h4, rd);
            // Enabled read edge recovers stored data
            step(6'h05, 1'b0, 1'b0, 2'h0, 1'b1, 18'h0, 18'h3ffff);
            @(posedge mclk);
        end
        // Port B old-data write of the low byte only, then read back
        ahb(1'b1, {24'h0, ERPC_CTRL_OFS}, 32'h0, rd);
        PB.put(6'h09, 1'b0, 1'b1, 2'h1, 1'b1, 18'h3ffff);
        @(posedge mclk);
        PB.put(6'h09, 1'b0, 1'b0, 2'h0, 1'b1, 18'h0);
        @(negedge mclk);
        chk("q_b", 32'h0, {14'h0, q_b});
        @(posedge mclk);
        PB.put(6'h09, 1'b0, 1'b0, 2'h0, 1'b0, 18'h0);
        @(negedge mclk);
        chk("q_b", 32'h1ff, {14'h0, q_b});
        final_report();
    end
endmodule : embedded_ram_port_controls_bench
